/* verilog/pwrsc_power_state_controller.sv */
// power state controller: sleep entry, peripheral and clock gating, wake sequencing
`timescale 1ns/1ps
`include "pwrsc_map.svh"

// Overview of operation
// - one active state plus idle, standby and power-down low-power states.
// - every low-power state entered from active; core halted while asleep.
// - enabled wake interrupt returns to active, ISR runs, then resume after entry.
// - reset ends any low-power state; execution restarts from the reset vector.
// - register file, SRAM and peripheral registers keep contents while asleep.
// - with no enabled wake interrupt, device sleeps until reset.
// - idle stops only the core; everything else runs; all interrupts wake.
// - standby keeps watchdog, brownout, event routing, periodic timer; those with a run-in-standby bit follow it, others stop.
// - standby gates RTC counter by its bit; power-down stops RTC counter, keeps periodic timer.
// - power-down keeps brownout, watchdog, event routing, periodic timer only.
// - power-down wakes on pin change, periodic timer, level monitor, address match, logic; pin change only with pin_async set.
// - standby wakes on listed sources; all other interrupts only wake from idle; logic wakes power-down but not standby.
// - main clock per state; watchdog and brownout oscillators always; control timer idle.
// - wake latency six clocks, plus oscillator start-up in standby and power-down.
// - in power-down only low-power oscillator and RTC clock may run.
// - with brownout fuse code 3, wake also waits for brownout ready.
// - debug break while asleep forces return to active.
// - run-time debugging without break leaves behaviour unchanged.
// - mode code 0 idle, 1 standby, 2 power-down, 3 reserved.
module pwrsc_power_state_controller #(
    parameter int OSC_STARTUP_CLK = `PWRSC_OSC_STARTUP_DEFAULT
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] low_power_mode_select_in,
    input wire logic low_power_entry_enable_in,
    input wire logic sleep_instr_in,
    input wire pwrsc_pkg::pwrsc_wake_t wake_req_in,
    input wire pwrsc_pkg::pwrsc_run_in_standby_t run_in_standby_in,
    input wire logic [1:0] brownout_fuse_in,
    input wire logic brownout_ready_in,
    input wire logic debug_break_in,
    output logic core_run_out,
    output logic wake_irq_out,
    output pwrsc_pkg::pwrsc_state_t state_out,
    output pwrsc_pkg::pwrsc_periph_en_t periph_en_out,
    output pwrsc_pkg::pwrsc_clk_en_t clk_en_out
);
    localparam int WAKE_CLK = `PWRSC_WAKE_CLK;
    localparam int CNT_W = $clog2(WAKE_CLK + OSC_STARTUP_CLK + 1);

    pwrsc_pkg::pwrsc_state_t state_q;
    pwrsc_pkg::pwrsc_state_t state_d;
    logic [CNT_W-1:0] wake_cnt_q;
    logic [CNT_W-1:0] wake_load;
    logic wake_by_irq_q;
    logic irq_wake;
    logic any_wake;
    logic entry_ok;
    logic wake_done;
    logic brownout_wait;

    // each state wakes on its own source list; in standby the rtc wakes only with its run-in-standby bit
    always_comb begin
        irq_wake = 1'b0;
        case (state_q)
            pwrsc_pkg::PWRSC_IDLE: begin
                irq_wake = |wake_req_in;
            end
            pwrsc_pkg::PWRSC_STANDBY: begin
                irq_wake = wake_req_in.pin_change | wake_req_in.level_monitor
                    | (wake_req_in.rtc & run_in_standby_in.rtc) | wake_req_in.periodic_timer
                    | wake_req_in.two_wire_addr | wake_req_in.usart_sof
                    | wake_req_in.adc_touch | wake_req_in.capture;
            end
            pwrsc_pkg::PWRSC_POWER_DOWN: begin
                irq_wake = (wake_req_in.pin_change & wake_req_in.pin_async)
                    | wake_req_in.periodic_timer | wake_req_in.level_monitor
                    | wake_req_in.two_wire_addr | wake_req_in.config_logic;
            end
            default: begin
                irq_wake = 1'b0;
            end
        endcase
    end

    // a break wakes even with nothing pending; no wake source means sleep till reset
    assign any_wake = irq_wake | debug_break_in;

    // entry only on the instruction with enable set and a defined mode
    assign entry_ok = sleep_instr_in & low_power_entry_enable_in
        & (low_power_mode_select_in != 2'h3);

    // idle keeps the main clock, so only the fixed six clocks apply
    always_comb begin
        if (state_q == pwrsc_pkg::PWRSC_IDLE) begin
            wake_load = CNT_W'(WAKE_CLK - 1);
        end else begin
            wake_load = CNT_W'(WAKE_CLK + OSC_STARTUP_CLK - 1);
        end
    end

    assign brownout_wait = (brownout_fuse_in == `PWRSC_BROWNOUT_WAIT_CODE)
        & ~brownout_ready_in;
    assign wake_done = (wake_cnt_q == '0) & ~brownout_wait;

    always_comb begin
        state_d = state_q;
        case (state_q)
            pwrsc_pkg::PWRSC_ACTIVE: begin
                if (entry_ok) begin
                    case (low_power_mode_select_in)
                        `PWRSC_MODE_IDLE: state_d = pwrsc_pkg::PWRSC_IDLE;
                        `PWRSC_MODE_STANDBY: state_d = pwrsc_pkg::PWRSC_STANDBY;
                        `PWRSC_MODE_POWER_DOWN: state_d = pwrsc_pkg::PWRSC_POWER_DOWN;
                        default: state_d = pwrsc_pkg::PWRSC_ACTIVE;
                    endcase
                end
            end
            pwrsc_pkg::PWRSC_IDLE,
            pwrsc_pkg::PWRSC_STANDBY,
            pwrsc_pkg::PWRSC_POWER_DOWN: begin
                if (any_wake) begin
                    state_d = pwrsc_pkg::PWRSC_WAKING;
                end
            end
            pwrsc_pkg::PWRSC_WAKING: begin
                if (wake_done) begin
                    state_d = pwrsc_pkg::PWRSC_ACTIVE;
                end
            end
            default: begin
                state_d = pwrsc_pkg::PWRSC_ACTIVE;
            end
        endcase
    end

    // reset from any state lands in active; the core restarts at its vector
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= pwrsc_pkg::PWRSC_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_cnt_q <= '0;
        end else if (state_q != pwrsc_pkg::PWRSC_WAKING) begin
            wake_cnt_q <= wake_load;
        end else if (wake_cnt_q != '0) begin
            wake_cnt_q <= wake_cnt_q - CNT_W'(1);
        end
    end

    // remember whether an interrupt (not just a break) caused the wake
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_by_irq_q <= 1'b0;
        end else if (state_q != pwrsc_pkg::PWRSC_WAKING) begin
            wake_by_irq_q <= irq_wake;
        end
    end

    // core resumes and takes the isr before the instruction after entry
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_irq_out <= 1'b0;
        end else begin
            wake_irq_out <= (state_q == pwrsc_pkg::PWRSC_WAKING) & wake_done
                & wake_by_irq_q;
        end
    end

    assign state_out = state_q;
    // no reset is issued to storage on entry or exit, so contents survive
    assign core_run_out = (state_q == pwrsc_pkg::PWRSC_ACTIVE);

    always_comb begin
        periph_en_out = '1;
        clk_en_out = '1;
        case (state_q)
            pwrsc_pkg::PWRSC_IDLE: begin
                periph_en_out.cpu = 1'b0;
                clk_en_out = '1;
            end
            pwrsc_pkg::PWRSC_STANDBY: begin
                periph_en_out.cpu = 1'b0;
                periph_en_out.rtc = run_in_standby_in.rtc;
                periph_en_out.periodic_timer = 1'b1;
                periph_en_out.config_logic = run_in_standby_in.config_logic;
                periph_en_out.comparator = run_in_standby_in.comparator;
                periph_en_out.adc_touch = run_in_standby_in.adc_touch;
                periph_en_out.dac = run_in_standby_in.dac;
                periph_en_out.capture = run_in_standby_in.capture;
                periph_en_out.others = 1'b0;
                clk_en_out.main_osc = run_in_standby_in.main_osc_req;
                clk_en_out.rtc_clk = run_in_standby_in.rtc;
                clk_en_out.config_logic_clk = run_in_standby_in.config_logic;
                clk_en_out.control_timer_clk = 1'b0;
            end
            pwrsc_pkg::PWRSC_POWER_DOWN: begin
                periph_en_out = '0;
                periph_en_out.periodic_timer = 1'b1;
                periph_en_out.watchdog = 1'b1;
                periph_en_out.brownout = 1'b1;
                periph_en_out.event_routing = 1'b1;
                clk_en_out = '0;
                clk_en_out.rtc_clk = 1'b1;
                clk_en_out.watchdog_osc = 1'b1;
                clk_en_out.brownout_osc = 1'b1;
            end
            pwrsc_pkg::PWRSC_WAKING: begin
                periph_en_out.cpu = 1'b0;
            end
            default: begin
                periph_en_out = '1;
                clk_en_out = '1;
            end
        endcase
        // control timer clock runs only while awake or in idle
        if (state_q != pwrsc_pkg::PWRSC_IDLE && state_q != pwrsc_pkg::PWRSC_ACTIVE) begin
            clk_en_out.control_timer_clk = 1'b0;
        end
    end
endmodule : pwrsc_power_state_controller

/* include/pwrsc_map.svh */
// constants for the power state controller: mode codes and timing counts
`ifndef PWRSC_MAP_SVH
`define PWRSC_MAP_SVH
`define PWRSC_MODE_IDLE 2'h0
`define PWRSC_MODE_STANDBY 2'h1
`define PWRSC_MODE_POWER_DOWN 2'h2
`define PWRSC_WAKE_CLK 6
`define PWRSC_BROWNOUT_WAIT_CODE 2'h3
`define PWRSC_OSC_STARTUP_DEFAULT 64
`endif

/* include/pwrsc_pkg.sv */
// types for the power state controller
package pwrsc_pkg;
    typedef enum logic [4:0] {
        PWRSC_ACTIVE = 5'h01,
        PWRSC_IDLE = 5'h02,
        PWRSC_STANDBY = 5'h04,
        PWRSC_POWER_DOWN = 5'h08,
        PWRSC_WAKING = 5'h10
    } pwrsc_state_t;

    // wake request sources
    typedef struct packed {
        logic pin_change;
        logic pin_async;
        logic level_monitor;
        logic rtc;
        logic periodic_timer;
        logic two_wire_addr;
        logic usart_sof;
        logic adc_touch;
        logic capture;
        logic config_logic;
        logic other;
    } pwrsc_wake_t;

    // run-in-standby bits of the peripherals that have one
    typedef struct packed {
        logic rtc;
        logic config_logic;
        logic comparator;
        logic adc_touch;
        logic dac;
        logic capture;
        logic main_osc_req;
    } pwrsc_run_in_standby_t;

    // per-peripheral run enables
    typedef struct packed {
        logic cpu;
        logic rtc;
        logic periodic_timer;
        logic watchdog;
        logic brownout;
        logic event_routing;
        logic config_logic;
        logic comparator;
        logic adc_touch;
        logic dac;
        logic capture;
        logic others;
    } pwrsc_periph_en_t;

    // clock source enables
    typedef struct packed {
        logic main_osc;
        logic rtc_clk;
        logic watchdog_osc;
        logic brownout_osc;
        logic config_logic_clk;
        logic control_timer_clk;
    } pwrsc_clk_en_t;
endpackage : pwrsc_pkg

/* dv/pwrsc_checker_properties.sv */
// port assertions for the power state controller
`timescale 1ns/1ps
module pwrsc_checker (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] low_power_mode_select_in,
    input wire logic low_power_entry_enable_in,
    input wire logic sleep_instr_in,
    input wire pwrsc_pkg::pwrsc_wake_t wake_req_in,
    input wire pwrsc_pkg::pwrsc_run_in_standby_t run_in_standby_in,
    input wire logic [1:0] brownout_fuse_in,
    input wire logic brownout_ready_in,
    input wire logic debug_break_in,
    input wire logic core_run_out,
    input wire logic wake_irq_out,
    input wire pwrsc_pkg::pwrsc_state_t state_out,
    input wire pwrsc_pkg::pwrsc_periph_en_t periph_en_out,
    input wire pwrsc_pkg::pwrsc_clk_en_t clk_en_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire logic asleep = |state_out[3:1];
    wire logic take = state_out[0] && sleep_instr_in;
    a_sleep_halts: assert property (asleep |-> !core_run_out) else $error("core runs asleep");
    a_entry_taken: assert property (take && low_power_entry_enable_in && low_power_mode_select_in != 2'h3
        |=> state_out == (5'h02 << $past(low_power_mode_select_in))) else $error("bad entry");
    a_entry_refused: assert property (take && (!low_power_entry_enable_in || low_power_mode_select_in == 2'h3)
        |=> state_out[0] && core_run_out) else $error("refused entry taken");
    a_powerdown_ignores: assert property (state_out[3] && !debug_break_in
        && !(wake_req_in.periodic_timer || wake_req_in.level_monitor || wake_req_in.two_wire_addr
        || wake_req_in.config_logic || (wake_req_in.pin_change && wake_req_in.pin_async))
        |=> state_out[3]) else $error("power-down left");
    a_break_wakes: assert property (asleep && debug_break_in |=> state_out[4]) else $error("break ignored");
    a_idle_latency: assert property (state_out[1] && wake_req_in.other && brownout_fuse_in != 2'h3
        |=> state_out[4] [*6] ##1 (state_out[0] && wake_irq_out)) else $error("idle wake timing");
    a_brownout_holds: assert property (state_out[4] && brownout_fuse_in == 2'h3 && !brownout_ready_in
        |=> !state_out[0]) else $error("woke before brownout ready");
    a_powerdown_gating: assert property (state_out[3] |-> periph_en_out.periodic_timer
        && periph_en_out.watchdog && periph_en_out.brownout && periph_en_out.event_routing
        && !periph_en_out.rtc && !periph_en_out.config_logic
        && !periph_en_out.others && !clk_en_out.main_osc && !clk_en_out.control_timer_clk)
        else $error("power-down gating");
    a_standby_gating: assert property (state_out[2] |-> periph_en_out.config_logic == run_in_standby_in.config_logic
        && periph_en_out.rtc == run_in_standby_in.rtc && periph_en_out.watchdog && !periph_en_out.others
        && !clk_en_out.control_timer_clk) else $error("standby gating");
endmodule : pwrsc_checker

bind pwrsc_power_state_controller pwrsc_checker u_chk (.ref_clk_in, .rst_in, .low_power_mode_select_in,
    .low_power_entry_enable_in, .sleep_instr_in, .wake_req_in, .run_in_standby_in, .brownout_fuse_in,
    .brownout_ready_in, .debug_break_in, .core_run_out, .wake_irq_out, .state_out, .periph_en_out,
    .clk_en_out);

/* dv/pwrsc_core_model.sv */
// core and interrupt logic model facing the power state controller
`timescale 1ns/1ps
module pwrsc_core_model (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic sleep_go_in,
    input wire pwrsc_pkg::pwrsc_wake_t wake_set_in,
    input wire logic core_run_in,
    input wire logic wake_irq_in,
    output logic sleep_instr_out,
    output pwrsc_pkg::pwrsc_wake_t wake_req_out
);
    // the entry instruction only issues while the core executes
    assign sleep_instr_out = sleep_go_in & core_run_in;
    // pending flags stay until the service routine runs, so a refused source lingers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_req_out <= '0;
        end else if (wake_irq_in) begin
            wake_req_out <= wake_set_in;
        end else begin
            wake_req_out <= wake_req_out | wake_set_in;
        end
    end
endmodule : pwrsc_core_model

/* dv/tb_power_state_controller.sv */
// self-checking bench for the power state controller
`timescale 1ns/1ps
module tb_power_state_controller;
    localparam int OSC = 2;
    logic ref_clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic [1:0] mode = 2'h0;
    logic en = 1'h0;
    logic go = 1'h0;
    logic dbg = 1'h0;
    logic brownout_rdy = 1'h0;
    logic [1:0] fuse = 2'h0;
    logic [1:0] m;
    pwrsc_pkg::pwrsc_wake_t wset = '0;
    pwrsc_pkg::pwrsc_wake_t wreq;
    pwrsc_pkg::pwrsc_run_in_standby_t rsb = '0;
    pwrsc_pkg::pwrsc_state_t st;
    logic instr;
    logic core_run;
    logic irq;
    int errors = 0;
    int checks_done = 0;
    int seed = 26657;
    int n;
    int b;
    always #25 ref_clk_in = ~ref_clk_in;
    pwrsc_core_model core (.ref_clk_in, .rst_in, .sleep_go_in(go), .wake_set_in(wset),
        .core_run_in(core_run), .wake_irq_in(irq), .sleep_instr_out(instr), .wake_req_out(wreq));
    pwrsc_power_state_controller #(.OSC_STARTUP_CLK(OSC)) DUT (.ref_clk_in, .rst_in,
        .low_power_mode_select_in(mode), .low_power_entry_enable_in(en), .sleep_instr_in(instr),
        .wake_req_in(wreq), .run_in_standby_in(rsb), .brownout_fuse_in(fuse),
        .brownout_ready_in(brownout_rdy),
        .debug_break_in(dbg), .core_run_out(core_run), .wake_irq_out(irq), .state_out(st),
        .periph_en_out(), .clk_en_out());
    task step;
        @(posedge ref_clk_in);
        #5;
    endtask : step
    task chk(input string what, input logic [4:0] exp, input logic [4:0] got);
        checks_done++;
        if (exp !== got) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task sleep(input logic [1:0] sm, input logic se);
        mode = sm;
        en = se;
        go = 1'h1;
        step;
        go = 1'h0;
    endtask : sleep
    task wake(input int bit_no);
        wset = 11'h001 << bit_no;
        wset.pin_async = bit_no == 10;
        step;
        wset = '0;
    endtask : wake
    task wait_active;
        n = 0;
        while (st !== pwrsc_pkg::PWRSC_ACTIVE && n < 300) begin
            step;
            n++;
        end
    endtask : wait_active
    // sources a mode may wake on; rtc (gating varies) and pit (always wakes) left out of standby
    function logic ok(input logic [1:0] om, input int ob);
        case (om)
            2'h0: return ob != 9;
            2'h1: return ob inside {10, 8, 5, 4, 3, 2};
            default: return ob inside {10, 8, 6, 5, 1};
        endcase
    endfunction : ok
    function int lat(input logic [1:0] lm);
        return (lm == 2'h0) ? 7 : 7 + OSC;
    endfunction : lat
    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #(50 * 20000);
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (20) step;
        rst_in = 1'h0;
        chk("reset state", 5'h01, st);
        sleep(2'h0, 1'h0);
        chk("no enable", 5'h01, st);
        sleep(2'h3, 1'h1);
        chk("reserved", 5'h01, st);
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 2'h0 : 2'($unsigned($random(seed)) % 3);
            fuse = 2'($unsigned($random(seed)) % 3);
            brownout_rdy = 1'($random(seed));
            rsb = 7'($random(seed));
            sleep(m, 1'h1);
            chk("entered", 5'h02 << m, st);
            chk("halted", 5'h00, core_run);
            do b = $unsigned($random(seed)) % 11; while (!ok(m, b));
            if (i == 0) b = 0;
            wake(b);
            wait_active;
            chk("latency", 5'(lat(m)), 5'(n));
            chk("irq", 5'h01, irq);
        end
        sleep(2'h2, 1'h1);
        // pin change without asynchronous sensing plus a source that power-down refuses
        wset.pin_change = 1'h1;
        wset.other = 1'h1;
        step;
        wset = '0;
        repeat (10) step;
        chk("power-down held", 5'h08, st);
        rst_in = 1'h1;
        step;
        rst_in = 1'h0;
        chk("reset wakes", 5'h01, st);
        sleep(2'h1, 1'h1);
        dbg = 1'h1;
        step;
        dbg = 1'h0;
        wait_active;
        chk("break wake", 5'h01, st);
        chk("break irq", 5'h00, irq);
        fuse = 2'h3;
        brownout_rdy = 1'h0;
        sleep(2'h0, 1'h1);
        wake(0);
        repeat (20) step;
        chk("brownout wait", 5'h10, st);
        brownout_rdy = 1'h1;
        wait_active;
        chk("brownout ready", 5'h01, st);
        tally_and_finish;
    end
endmodule : tb_power_state_controller
